// [core/timer_match_pkg.sv]
// shared offsets, field widths, reset values and encodings of the match/prescale block
package timer_match_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LOW_W = 16;
  localparam int PRE_W = 8;
  localparam int IRQ_W = 4;

  localparam logic [ADDR_W-1:0] OFS_A_MATCH = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_B_MATCH = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_A_PRESCALE = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_B_PRESCALE = 8'h3c;
  localparam logic [ADDR_W-1:0] OFS_A_PRESCALE_MATCH = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_B_PRESCALE_MATCH = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_A_VALUE = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_B_VALUE = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_MODE_CFG = 8'h58;

  localparam logic [DATA_W-1:0] RST_A_MATCH = 32'hffff_ffff;
  localparam logic [LOW_W-1:0] RST_B_MATCH_LOW = 16'hffff;
  localparam logic [PRE_W-1:0] RST_PRESCALE = 8'h00;
  localparam logic [PRE_W-1:0] RST_PRESCALE_MATCH = 8'h00;

  // mode configuration fields
  localparam int CFG_RTC_BIT = 0;
  localparam int CFG_A_MODE_LSB = 1;
  localparam int CFG_B_MODE_LSB = 3;
  localparam int MODE_W = 2;

  // interrupt status / mask bit positions
  localparam int IRQ_A_MATCH = 0;
  localparam int IRQ_B_MATCH = 1;
  localparam int IRQ_A_EDGE_DONE = 2;
  localparam int IRQ_B_EDGE_DONE = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [MODE_W-1:0] {
    MODE_TIMER = 2'h0,
    MODE_EDGE = 2'h1,
    MODE_PWM = 2'h2
  } timer_mode_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;
endpackage

// [core/match_unit.sv]
// one timer's match compare, pwm level, edge counter and value capture
`timescale 1ns/1ps
module match_unit #(
  parameter int CW = 32,
  parameter int LW = 16
) (
  input wire logic aclk,               // system clock
  input wire logic aresetn,            // sync reset, low active
  input wire logic ce,                 // clock enable
  input wire logic enable,             // match value in use
  input wire logic edge_mode,          // edge count mode
  input wire logic pwm_mode,           // pwm mode
  input wire logic [CW-1:0] match_value, // full compare value
  input wire logic [CW-1:0] count_value, // extended count
  input wire logic [LW-1:0] interval_load, // interval load value
  input wire logic [LW-1:0] match_low,  // low match field
  input wire logic [LW-1:0] live_count, // running 16-bit count
  input wire logic edge_in,             // edge event pulse
  output logic match_pulse,             // one-cycle match event
  output logic pwm_level,               // pwm output level
  output logic edge_done,               // one-cycle edge target reached
  output logic [LW-1:0] value           // timer value view
);
  logic hit;
  logic hit_d_ff, nxt_hit_d;
  logic match_pulse_ff, nxt_match_pulse;
  logic pwm_ff, nxt_pwm;
  logic done_ff, nxt_done;
  logic [LW-1:0] edges_ff, nxt_edges;
  logic [LW-1:0] value_ff, nxt_value;
  logic [LW-1:0] target;
  logic [LW-1:0] edges_inc;

  assign hit = enable && (match_value == count_value);
  assign target = interval_load - match_low;
  assign edges_inc = edges_ff + 1'b1;

  always_comb begin
    nxt_hit_d = hit;
    nxt_match_pulse = hit && !hit_d_ff;
    // output high until the count falls to the match value
    nxt_pwm = enable && pwm_mode && (count_value > match_value);
    nxt_done = 1'b0;
    nxt_edges = edges_ff;
    if (!(enable && edge_mode)) begin
      nxt_edges = '0;
    end else if (edge_in) begin
      if (edges_inc >= target) begin
        nxt_done = 1'b1;
        nxt_edges = '0;
      end else begin
        nxt_edges = edges_inc;
      end
    end
    // edge mode shows the time of the last edge, else the live count
    nxt_value = live_count;
    if (edge_mode && !edge_in) begin
      nxt_value = value_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_d_ff <= 1'b0;
      match_pulse_ff <= 1'b0;
      pwm_ff <= 1'b0;
      done_ff <= 1'b0;
      edges_ff <= '0;
      value_ff <= '1;
    end else if (ce) begin
      hit_d_ff <= nxt_hit_d;
      match_pulse_ff <= nxt_match_pulse;
      pwm_ff <= nxt_pwm;
      done_ff <= nxt_done;
      edges_ff <= nxt_edges;
      value_ff <= nxt_value;
    end
  end

  assign match_pulse = match_pulse_ff;
  assign pwm_level = pwm_ff;
  assign edge_done = done_ff;
  assign value = value_ff;
endmodule

// [core/timer_match_prescale_regs.sv]
// match and prescale registers of a two-part timer, AXI4-Lite slave with interrupts
//
// Functional notes
// - match used only in rtc, pwm, edge modes
// - pwm duty from low match and interval load
// - edges counted equal interval load minus match
// - timer_b low match RW, resets all ones
// - timer_b match upper half reserved, read-only
// - separate writable prescaler for each timer
// - timer_a prescale match widens compare to 24
// - timer_b prescale match 8 bits, reset zero
// - rtc mode compares full 32-bit timer_a match
// - edge mode value holds last edge time
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module timer_match_prescale_regs (
  input wire logic aclk,                                  // system clock
  input wire logic aresetn,                               // sync reset, low active
  input wire logic ce,                                    // clock enable, freezes all
  input wire logic [timer_match_pkg::ADDR_W-1:0] awaddr,  // write address
  input wire logic [2:0] awprot,                          // write protection, unused
  input wire logic awvalid,                               // write address valid
  output logic awready,                                   // write address ready
  input wire logic [timer_match_pkg::DATA_W-1:0] wdata,   // write data
  input wire logic [3:0] wstrb,                           // write byte strobes
  input wire logic wvalid,                                // write data valid
  output logic wready,                                    // write data ready
  output logic [1:0] bresp,                               // write response
  output logic bvalid,                                    // write response valid
  input wire logic bready,                                // write response ready
  input wire logic [timer_match_pkg::ADDR_W-1:0] araddr,  // read address
  input wire logic [2:0] arprot,                          // read protection, unused
  input wire logic arvalid,                               // read address valid
  output logic arready,                                   // read address ready
  output logic [timer_match_pkg::DATA_W-1:0] rdata,       // read data
  output logic [1:0] rresp,                               // read response
  output logic rvalid,                                    // read data valid
  input wire logic rready,                                // read data ready
  input wire logic [timer_match_pkg::DATA_W-1:0] rtc_count, // 32-bit rtc count
  input wire logic [timer_match_pkg::LOW_W-1:0] a_count,  // timer_a 16-bit count
  input wire logic [timer_match_pkg::LOW_W-1:0] b_count,  // timer_b 16-bit count
  input wire logic [timer_match_pkg::PRE_W-1:0] a_prescale_count, // timer_a prescaler count
  input wire logic [timer_match_pkg::PRE_W-1:0] b_prescale_count, // timer_b prescaler count
  input wire logic [timer_match_pkg::LOW_W-1:0] a_interval_load, // timer_a interval load
  input wire logic [timer_match_pkg::LOW_W-1:0] b_interval_load, // timer_b interval load
  input wire logic a_edge,                                // timer_a edge event pulse
  input wire logic b_edge,                                // timer_b edge event pulse
  output logic [timer_match_pkg::PRE_W-1:0] a_prescale,   // timer_a prescaler to core
  output logic [timer_match_pkg::PRE_W-1:0] b_prescale,   // timer_b prescaler to core
  output logic rtc_mode,                                  // 32-bit rtc configuration
  output timer_match_pkg::timer_mode_t a_mode,            // timer_a mode
  output timer_match_pkg::timer_mode_t b_mode,            // timer_b mode
  output logic a_pwm,                                     // timer_a pwm output
  output logic b_pwm,                                     // timer_b pwm output
  output logic a_match,                                   // timer_a match pulse
  output logic b_match,                                   // timer_b match pulse
  output logic irq                                        // level interrupt
);
  import timer_match_pkg::*;

  localparam int LANES = DATA_W / 8;

  // register state
  logic [DATA_W-1:0] a_match_ff, nxt_a_match;
  logic [LOW_W-1:0] b_match_low_ff, nxt_b_match_low;
  logic [PRE_W-1:0] a_pre_ff, nxt_a_pre;
  logic [PRE_W-1:0] b_pre_ff, nxt_b_pre;
  logic [PRE_W-1:0] a_pm_ff, nxt_a_pm;
  logic [PRE_W-1:0] b_pm_ff, nxt_b_pm;
  logic rtc_ff, nxt_rtc;
  timer_mode_t a_mode_ff, nxt_a_mode;
  timer_mode_t b_mode_ff, nxt_b_mode;
  logic [IRQ_W-1:0] status_ff, nxt_status;
  logic [IRQ_W-1:0] mask_ff, nxt_mask;

  // bus state
  wr_state_t wr_state_ff, nxt_wr_state;
  rd_state_t rd_state_ff, nxt_rd_state;
  logic aw_ff, nxt_aw;
  logic w_ff, nxt_w;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [LANES-1:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  logic aw_take, w_take, do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data, wr_mask;
  logic [LANES-1:0] wr_strb;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;

  logic a_en, b_en;
  logic [DATA_W-1:0] a_cmp_match, a_cmp_count, b_cmp_match, b_cmp_count;
  logic a_hit_pulse, b_hit_pulse, a_done, b_done;
  logic [LOW_W-1:0] a_value, b_value;
  logic [IRQ_W-1:0] events;

  // handshakes stay low while frozen so nothing is taken
  assign awready = ce && (wr_state_ff == WR_COLLECT) && !aw_ff;
  assign wready = ce && (wr_state_ff == WR_COLLECT) && !w_ff;
  assign arready = ce && (rd_state_ff == RD_IDLE);
  assign bvalid = (wr_state_ff == WR_RESP);
  assign rvalid = (rd_state_ff == RD_DATA);
  assign bresp = bresp_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_addr = aw_ff ? awaddr_ff : awaddr;
  assign wr_data = w_ff ? wdata_ff : wdata;
  assign wr_strb = w_ff ? wstrb_ff : wstrb;
  // address and data may arrive in either order
  assign do_write = ce && (wr_state_ff == WR_COLLECT) && (aw_ff || aw_take) && (w_ff || w_take);

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      wr_mask[i*8 +: 8] = {8{wr_strb[i]}};
    end
  end

  // write channel
  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bresp = bresp_ff;
    unique case (wr_state_ff)
      WR_COLLECT: begin
        if (aw_take) begin
          nxt_aw = 1'b1;
          nxt_awaddr = awaddr;
        end
        if (w_take) begin
          nxt_w = 1'b1;
          nxt_wdata = wdata;
          nxt_wstrb = wstrb;
        end
        if (do_write) begin
          nxt_aw = 1'b0;
          nxt_w = 1'b0;
          nxt_wr_state = WR_RESP;
          nxt_bresp = RESP_OKAY;
          unique case (wr_addr)
            OFS_A_MATCH, OFS_B_MATCH, OFS_A_PRESCALE, OFS_B_PRESCALE,
            OFS_A_PRESCALE_MATCH, OFS_B_PRESCALE_MATCH, OFS_A_VALUE, OFS_B_VALUE,
            OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_MODE_CFG: nxt_bresp = RESP_OKAY;
            default: nxt_bresp = RESP_SLVERR;
          endcase
        end
      end
      WR_RESP: begin
        if (bready) begin
          nxt_wr_state = WR_COLLECT;
        end
      end
    endcase
  end

  // register writes and sticky status
  always_comb begin
    nxt_a_match = a_match_ff;
    nxt_b_match_low = b_match_low_ff;
    nxt_a_pre = a_pre_ff;
    nxt_b_pre = b_pre_ff;
    nxt_a_pm = a_pm_ff;
    nxt_b_pm = b_pm_ff;
    nxt_rtc = rtc_ff;
    nxt_a_mode = a_mode_ff;
    nxt_b_mode = b_mode_ff;
    nxt_mask = mask_ff;
    nxt_status = status_ff;
    if (do_write) begin
      unique case (wr_addr)
        OFS_A_MATCH: nxt_a_match = (a_match_ff & ~wr_mask) | (wr_data & wr_mask);
        OFS_B_MATCH: begin
          // upper half is reserved: writes there are dropped
          nxt_b_match_low = (b_match_low_ff & ~wr_mask[LOW_W-1:0])
                          | (wr_data[LOW_W-1:0] & wr_mask[LOW_W-1:0]);
        end
        OFS_A_PRESCALE: if (wr_strb[0]) nxt_a_pre = wr_data[PRE_W-1:0];
        OFS_B_PRESCALE: if (wr_strb[0]) nxt_b_pre = wr_data[PRE_W-1:0];
        OFS_A_PRESCALE_MATCH: if (wr_strb[0]) nxt_a_pm = wr_data[PRE_W-1:0];
        OFS_B_PRESCALE_MATCH: if (wr_strb[0]) nxt_b_pm = wr_data[PRE_W-1:0];
        OFS_IRQ_MASK: if (wr_strb[0]) nxt_mask = wr_data[IRQ_W-1:0];
        OFS_IRQ_STATUS: if (wr_strb[0]) nxt_status = status_ff & ~wr_data[IRQ_W-1:0];
        OFS_MODE_CFG: begin
          if (wr_strb[0]) begin
            nxt_rtc = wr_data[CFG_RTC_BIT];
            nxt_a_mode = timer_mode_t'(wr_data[CFG_A_MODE_LSB +: MODE_W]);
            nxt_b_mode = timer_mode_t'(wr_data[CFG_B_MODE_LSB +: MODE_W]);
          end
        end
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    nxt_status = nxt_status | events;
  end

  // read channel
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (araddr)
      OFS_A_MATCH: begin
        rd_word[LOW_W-1:0] = a_match_ff[LOW_W-1:0];
        if (rtc_ff) rd_word = a_match_ff;
      end
      OFS_B_MATCH: rd_word[LOW_W-1:0] = b_match_low_ff;
      OFS_A_PRESCALE: rd_word[PRE_W-1:0] = a_pre_ff;
      OFS_B_PRESCALE: rd_word[PRE_W-1:0] = b_pre_ff;
      OFS_A_PRESCALE_MATCH: rd_word[PRE_W-1:0] = a_pm_ff;
      OFS_B_PRESCALE_MATCH: rd_word[PRE_W-1:0] = b_pm_ff;
      OFS_A_VALUE: rd_word[LOW_W-1:0] = a_value;
      OFS_B_VALUE: rd_word[LOW_W-1:0] = b_value;
      OFS_IRQ_STATUS: rd_word[IRQ_W-1:0] = status_ff;
      OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = mask_ff;
      OFS_MODE_CFG: begin
        rd_word[CFG_RTC_BIT] = rtc_ff;
        rd_word[CFG_A_MODE_LSB +: MODE_W] = a_mode_ff;
        rd_word[CFG_B_MODE_LSB +: MODE_W] = b_mode_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    unique case (rd_state_ff)
      RD_IDLE: begin
        if (arvalid && arready) begin
          nxt_rd_state = RD_DATA;
          nxt_rdata = rd_word;
          nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
      end
      RD_DATA: begin
        if (rready) begin
          nxt_rd_state = RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= WR_COLLECT;
      rd_state_ff <= RD_IDLE;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
      a_match_ff <= RST_A_MATCH;
      b_match_low_ff <= RST_B_MATCH_LOW;
      a_pre_ff <= RST_PRESCALE;
      b_pre_ff <= RST_PRESCALE;
      a_pm_ff <= RST_PRESCALE_MATCH;
      b_pm_ff <= RST_PRESCALE_MATCH;
      rtc_ff <= 1'b0;
      a_mode_ff <= MODE_TIMER;
      b_mode_ff <= MODE_TIMER;
      status_ff <= '0;
      mask_ff <= '0;
    end else if (ce) begin
      wr_state_ff <= nxt_wr_state;
      rd_state_ff <= nxt_rd_state;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bresp_ff <= nxt_bresp;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      a_match_ff <= nxt_a_match;
      b_match_low_ff <= nxt_b_match_low;
      a_pre_ff <= nxt_a_pre;
      b_pre_ff <= nxt_b_pre;
      a_pm_ff <= nxt_a_pm;
      b_pm_ff <= nxt_b_pm;
      rtc_ff <= nxt_rtc;
      a_mode_ff <= nxt_a_mode;
      b_mode_ff <= nxt_b_mode;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
    end
  end

  // compare values: rtc gives timer_a the full 32-bit pair; otherwise, and always for timer_b, prescale above low match
  assign a_en = rtc_ff || (a_mode_ff != MODE_TIMER);
  assign b_en = rtc_ff || (b_mode_ff != MODE_TIMER);
  always_comb begin
    a_cmp_match = '0;
    a_cmp_count = '0;
    b_cmp_match = '0;
    b_cmp_count = '0;
    if (rtc_ff) begin
      a_cmp_match = a_match_ff;
      a_cmp_count = rtc_count;
    end else begin
      a_cmp_match[LOW_W+PRE_W-1:0] = {a_pm_ff, a_match_ff[LOW_W-1:0]};
      a_cmp_count[LOW_W+PRE_W-1:0] = {a_prescale_count, a_count};
    end
    b_cmp_match[LOW_W+PRE_W-1:0] = {b_pm_ff, b_match_low_ff};
    b_cmp_count[LOW_W+PRE_W-1:0] = {b_prescale_count, b_count};
  end

  match_unit #(.CW(DATA_W), .LW(LOW_W)) u_a_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(a_en),
    .edge_mode(!rtc_ff && (a_mode_ff == MODE_EDGE)),
    .pwm_mode(!rtc_ff && (a_mode_ff == MODE_PWM)),
    .match_value(a_cmp_match),
    .count_value(a_cmp_count),
    .interval_load(a_interval_load),
    .match_low(a_match_ff[LOW_W-1:0]),
    .live_count(a_count),
    .edge_in(a_edge),
    .match_pulse(a_hit_pulse),
    .pwm_level(a_pwm),
    .edge_done(a_done),
    .value(a_value)
  );

  match_unit #(.CW(DATA_W), .LW(LOW_W)) u_b_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(b_en),
    .edge_mode(b_mode_ff == MODE_EDGE),
    .pwm_mode(b_mode_ff == MODE_PWM),
    .match_value(b_cmp_match),
    .count_value(b_cmp_count),
    .interval_load(b_interval_load),
    .match_low(b_match_low_ff),
    .live_count(b_count),
    .edge_in(b_edge),
    .match_pulse(b_hit_pulse),
    .pwm_level(b_pwm),
    .edge_done(b_done),
    .value(b_value)
  );

  always_comb begin
    events = '0;
    events[IRQ_A_MATCH] = a_hit_pulse;
    events[IRQ_B_MATCH] = b_hit_pulse;
    events[IRQ_A_EDGE_DONE] = a_done;
    events[IRQ_B_EDGE_DONE] = b_done;
  end

  assign a_match = a_hit_pulse;
  assign b_match = b_hit_pulse;
  assign a_prescale = a_pre_ff;
  assign b_prescale = b_pre_ff;
  assign rtc_mode = rtc_ff;
  assign a_mode = a_mode_ff;
  assign b_mode = b_mode_ff;
  assign irq = |(status_ff & mask_ff);
endmodule

// [test/timer_match_sva.sv]
// bus handshake and match event checks for the match/prescale block
`timescale 1ns/1ps
module timer_match_sva
  import timer_match_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic ce, // clock enable
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b response
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // read data
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic rtc_mode, // rtc config
  input wire timer_match_pkg::timer_mode_t b_mode, // b mode
  input wire logic a_match, // a match pulse
  input wire logic b_match // b match pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_b_wait;
    bvalid && !bready;
  endsequence

  a_b_resp_after: assert property (s_wr_taken |=> bvalid)
    else $error("write response missing");
  a_b_resp_hold: assert property (s_b_wait |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_after: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  a_ce_freeze: assert property (!ce |-> !(awready || wready || arready))
    else $error("ready while frozen");
  a_match_single: assert property (a_match && ce |=> !a_match)
    else $error("match pulse too long");
  a_b_match_mode: assert property (b_match |-> $past(rtc_mode || b_mode != MODE_TIMER))
    else $error("match in plain timer mode");
endmodule

bind timer_match_prescale_regs timer_match_sva timer_match_sva_inst (.*);

// [test/testbench.sv]
// self-checking bench for the match/prescale register block
`timescale 1ns/1ps
module testbench;
  import timer_match_pkg::*;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, a_edge, b_edge;
  logic awready, wready, bvalid, arready, rvalid, a_pwm, b_pwm, a_match, b_match, irq;
  logic rtc_mode;
  logic [7:0] awaddr, araddr, a_prescale_count, b_prescale_count, a_prescale, b_prescale;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [31:0] wdata, rdata, rtc_count;
  logic [15:0] a_count, b_count, a_interval_load, b_interval_load;
  timer_mode_t a_mode, b_mode;
  logic [7:0] ofs [4];
  int bad_count, num_checks, cyc, a_hits, b_hits;

  timer_match_prescale_regs timer_match_prescale_regs_inst (.*);

  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // runaway guard, tests need well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (b_match === 1'b1) b_hits++;
    if (a_match === 1'b1) a_hits++;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    // ready raised late so the response must be held
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    chk32({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    chk32(rdata, e);
    chk32({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic pulse_b;
    b_edge <= 1;
    @(posedge aclk);
    b_edge <= 0;
    @(posedge aclk);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, a_edge, b_edge} = '0;
    ce = 1;
    {awaddr, araddr, awprot, arprot, wstrb, wdata, rtc_count} = '0;
    {a_count, b_count, a_prescale_count, b_prescale_count} = '0;
    {a_interval_load, b_interval_load} = '0;
    ofs = '{OFS_A_PRESCALE, OFS_B_PRESCALE, OFS_A_PRESCALE_MATCH, OFS_B_PRESCALE_MATCH};
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    a_hits = 0;
    b_hits = 0;
    clk(16);
    aresetn <= 1;
    clk(1);
    rd(OFS_B_MATCH, 32'h0000ffff, RESP_OKAY);
    for (int i = 0; i < 4; i++) rd(ofs[i], 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) wr(ofs[i], 32'h50 + i, 4'hf, RESP_OKAY);
    for (int i = 0; i < 4; i++) rd(ofs[i], 32'h50 + i, RESP_OKAY);
    chk32({16'h0, a_prescale, b_prescale}, 32'h5051);
    wr(OFS_B_MATCH, 32'h0000a5c3, 4'hf, RESP_OKAY);
    wr(OFS_B_MATCH, 32'h00001200, 4'h2, RESP_OKAY);
    rd(OFS_B_MATCH, 32'h000012c3, RESP_OKAY);
    wr(8'h60, 32'h1, 4'hf, RESP_SLVERR);
    rd(8'h60, 32'h0, RESP_SLVERR);
    ce <= 0;
    clk(2);
    chk32({31'h0, awready}, 32'h0);
    ce <= 1;
    // compare value is 0x53_12c3; plain timer mode must stay silent
    b_count <= 16'h12c3;
    b_prescale_count <= 8'h53;
    clk(4);
    chk32(b_hits, 32'h0);
    b_prescale_count <= 8'h52;
    wr(OFS_MODE_CFG, 32'h10, 4'hf, RESP_OKAY);
    chk32({27'h0, rtc_mode, a_mode, b_mode}, 32'h2);
    clk(4);
    chk32(b_hits, 32'h0);
    b_prescale_count <= 8'h53;
    clk(4);
    chk32(b_hits, 32'h1);
    chk32({31'h0, b_pwm}, 32'h0);
    b_count <= 16'h12c4;
    clk(3);
    chk32({31'h0, b_pwm}, 32'h1);
    b_count <= 16'h0100;
    clk(3);
    chk32({31'h0, b_pwm}, 32'h0);
    b_prescale_count <= 8'h54;
    clk(3);
    chk32({31'h0, b_pwm}, 32'h1);
    rd(OFS_IRQ_STATUS, 32'h2, RESP_OKAY);
    chk32({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h2, 4'hf, RESP_OKAY);
    clk(2);
    chk32({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h2, 4'hf, RESP_OKAY);
    clk(2);
    chk32({31'h0, irq}, 32'h0);
    // edge count target is 10 - 7 = 3 edges
    wr(OFS_B_MATCH, 32'h7, 4'hf, RESP_OKAY);
    b_interval_load <= 16'd10;
    b_count <= 16'h0abc;
    wr(OFS_MODE_CFG, 32'h08, 4'hf, RESP_OKAY);
    pulse_b;
    pulse_b;
    b_count <= 16'h0def;
    clk(2);
    rd(OFS_B_VALUE, 32'h00000abc, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
    pulse_b;
    clk(2);
    rd(OFS_IRQ_STATUS, 32'h8, RESP_OKAY);
    wr(OFS_MODE_CFG, 32'h1, 4'hf, RESP_OKAY);
    chk32({27'h0, rtc_mode, a_mode, b_mode}, 32'h10);
    wr(OFS_A_MATCH, 32'h12345678, 4'hf, RESP_OKAY);
    rd(OFS_A_MATCH, 32'h12345678, RESP_OKAY);
    rtc_count <= 32'h12355678;
    clk(4);
    chk32(a_hits, 32'h0);
    rtc_count <= 32'h12345678;
    clk(4);
    chk32(a_hits, 32'h1);
    chk32({31'h0, a_pwm}, 32'h0);
    test_done;
  end
endmodule
